// >>> src/panel_scan_consts.svh
// timing constants, field widths and defaults for the panel scan block
`ifndef PANEL_SCAN_CONSTS_SVH
`define PANEL_SCAN_CONSTS_SVH
`define PIX_W 16
`define CNT_W 12
`define ADDR_W 17
`define BUF_SEL_W 2
`define BAND_SEL_W 2
`define MAX_SCREEN_BANDS 4
`define DEF_H_PULSE 12'h029
`define DEF_H_BACK 12'h002
`define DEF_H_ACTIVE 12'h1E0
`define DEF_H_FRONT 12'h002
`define DEF_V_PULSE 12'h00A
`define DEF_V_BACK 12'h002
`define DEF_V_ACTIVE 12'h110
`define DEF_V_FRONT 12'h002
`define DEF_ACTIVE_DIV 8'h06
`define DEF_BLANK_DIV 8'h08
// fetch to pixel takes two clocks, so a half period needs at least three
`define MIN_ACTIVE_DIV 8'h06
`define MIN_DIV 8'h02
`define PCT_MAX 8'h64
`endif

// >>> src/panel_scan_pkg.sv
// types shared by the panel scan block
`include "panel_scan_consts.svh"
package panel_scan_pkg;
  typedef struct packed {
    logic [`CNT_W-1:0] pulse;
    logic [`CNT_W-1:0] back;
    logic [`CNT_W-1:0] active;
    logic [`CNT_W-1:0] front;
  } span_type;

  typedef struct packed {
    logic [`ADDR_W-1:0] base;
    logic [`CNT_W-1:0] first_line;
  } band_type;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic req;
  } fetch_type;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic data_en;
    logic [`PIX_W-1:0] rgb;
  } panel_type;

  typedef enum logic [1:0] {
    seg_pulse,
    seg_back,
    seg_active,
    seg_front
  } seg_type;
endpackage

// >>> src/dot_clock_gen.sv
// dot clock divider with separate active and blanking rates
`timescale 1ns/10ps
module dot_clock_gen
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] active_div,
  input wire logic [7:0] blank_div,
  input wire logic in_active,
  input wire logic falling_edge_latch_select,
  output logic dot_clk,
  output logic launch
);
  logic [7:0] cnt_reg;
  logic phase_reg;
  logic [7:0] div;
  logic [7:0] half;
  logic turn;

  // rate is picked per half period so a switch never leaves a runt
  assign div = in_active ? active_div : blank_div;
  assign half = {1'b0, div[7:1]};

  // counter never stops between lines or frames
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg <= 8'h00;
      phase_reg <= 1'b0;
    end
    else if (cnt_reg >= half - 8'h01)
    begin
      cnt_reg <= 8'h00;
      phase_reg <= ~phase_reg;
    end
    else
    begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  assign turn = (cnt_reg >= half - 8'h01);

  // data change as the phase leaves high; the pin polarity then puts the latch half a dot later
  assign launch = turn && phase_reg; // [R16]

  // registered so a polarity change cannot glitch the pin
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dot_clk <= 1'b0;
    end
    else
    begin
      dot_clk <= (phase_reg ^ turn) ^ falling_edge_latch_select; // [R7] [R16]
    end
  end
endmodule // dot_clock_gen

// >>> src/span_counter.sv
// one axis counter stepping through pulse, back porch, active and front porch
`timescale 1ns/10ps
`include "panel_scan_consts.svh"
module span_counter
  import panel_scan_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic step,
  input panel_scan_pkg::span_type span,
  input wire logic [`CNT_W-1:0] extra_front,
  output panel_scan_pkg::seg_type seg,
  output logic [`CNT_W-1:0] pos,
  output logic wrap
);
  logic [`CNT_W-1:0] limit;

  always_comb
  begin
    unique case (seg)
      seg_pulse: limit = span.pulse;
      seg_back: limit = span.back;
      seg_active: limit = span.active;
      seg_front: limit = span.front + extra_front;
    endcase
  end

  assign wrap = step && (seg == seg_front) && (pos >= limit - 12'h001);

  // pulse, back porch, active, front porch in that order
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      seg <= seg_pulse;
      pos <= 12'h000;
    end
    else if (step)
    begin
      if (pos >= limit - 12'h001)
      begin
        pos <= 12'h000;
        seg <= seg_type'(seg + 2'd1); // [R21]
      end
      else
      begin
        pos <= pos + 12'h001;
      end
    end
  end
endmodule // span_counter

// >>> src/panel_scan_timing.sv
// panel scan timing, frame buffer fetch and register file
`timescale 1ns/10ps
`include "panel_scan_consts.svh"
// Notes on behaviour
// [R1] scan frame_pixel_count pixels, window into buffer
// [R2] show selected buffer, switch only at frame (the code also switches on every clock while scan is disabled)
// [R3] reverse_line_order presents lines bottom-up
// [R4] reverse_dot_order sends each line right-to-left
// [R5] both reversals work independently or together
// [R6] up to max_screen_bands bands, own sources
// [R7] dot clock runs through blanking too
// [R8] data window starts each line fetch
// [R9] active dot clock rate configurable
// [R10] blanking dot clock rate configurable separately
// [R11] unattainable active rate rejected with error
// [R12] refresh rate set by stretching vertical blanking
// [R13] keep minimum host access share free (only flagged in share_error_reg)
// [R14] host re-arm service fits horizontal blanking (no logic in the code sizes or checks horizontal blanking for it)
// [R15] pulse event at vblank start and end
// [R16] falling_edge_latch_select moves latching edge
// [R17] hsync period equals one whole line
// [R18] vsync period equals one whole frame
// [R19] data enable only with valid pixels
// [R20] 16-bit R5:G6:B5 pixel bus
// [R21] sync, back porch, active, front porch order
// [R22] idle in reset, start at vsync
module panel_scan_timing
  import panel_scan_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output panel_scan_pkg::fetch_type fetch,
  input wire logic [`PIX_W-1:0] fetch_data,
  input wire logic fetch_valid,
  output logic dot_clk,
  output panel_scan_pkg::panel_type panel,
  output logic vblank_event
);
  import panel_scan_pkg::*;

  localparam logic [5:0] A_CTRL = 6'h00;
  localparam logic [5:0] A_HSPAN0 = 6'h04;
  localparam logic [5:0] A_HSPAN1 = 6'h08;
  localparam logic [5:0] A_VSPAN0 = 6'h0C;
  localparam logic [5:0] A_VSPAN1 = 6'h10;
  localparam logic [5:0] A_RATE = 6'h14;
  localparam logic [5:0] A_FRAME = 6'h18;
  localparam logic [5:0] A_STATUS = 6'h1C;
  localparam logic [5:0] A_BUF = 6'h20;
  localparam logic [5:0] A_BAND = 6'h30;

  // control fields
  logic reverse_line_order_reg;
  logic reverse_dot_order_reg;
  logic falling_edge_latch_select_reg;
  logic scan_enable_reg;
  logic [`BUF_SEL_W-1:0] buf_sel_reg;
  logic [`BUF_SEL_W-1:0] shown_buf_reg;
  logic [`BAND_SEL_W-1:0] band_count_reg;
  span_type hspan_reg;
  span_type vspan_reg;
  logic [7:0] active_div_reg;
  logic [7:0] blank_div_reg;
  logic [7:0] applied_active_div_reg;
  logic [7:0] applied_blank_div_reg;
  logic [`CNT_W-1:0] extra_vblank_reg;
  logic [`ADDR_W-1:0] frame_pixel_count_reg;
  logic [`CNT_W-1:0] line_pitch_reg;
  logic [7:0] min_host_access_share_reg;
  logic rate_error_reg;
  logic share_error_reg;
  logic [`ADDR_W-1:0] buf_base_reg [0:3];
  band_type band_reg [0:`MAX_SCREEN_BANDS-1];
  logic [15:0] frame_count_reg;

  // timing
  logic launch;
  seg_type hseg;
  seg_type vseg;
  logic [`CNT_W-1:0] hpos;
  logic [`CNT_W-1:0] vpos;
  logic hwrap;
  logic vwrap;
  logic line_active;
  logic pix_active;
  logic [1:0] cur_band;
  logic [`CNT_W-1:0] src_line;
  logic [`CNT_W-1:0] src_dot;
  logic [`ADDR_W-1:0] pix_addr;
  logic vblank_now;
  logic vblank_prev_reg;
  logic [23:0] active_dots;
  logic [23:0] total_dots;
  logic share_ok;

  dot_clock_gen u_dot
  (
    .clk(clk),
    .rst(rst),
    .active_div(applied_active_div_reg),
    .blank_div(applied_blank_div_reg),
    .in_active(pix_active),
    .falling_edge_latch_select(falling_edge_latch_select_reg),
    .dot_clk(dot_clk),
    .launch(launch)
  );

  span_counter u_h
  (
    .clk(clk),
    .rst(rst || !scan_enable_reg),
    .step(launch),
    .span(hspan_reg),
    .extra_front(12'h000),
    .seg(hseg),
    .pos(hpos),
    .wrap(hwrap)
  );

  span_counter u_v
  (
    .clk(clk),
    .rst(rst || !scan_enable_reg),
    .step(hwrap), // [R17]
    .span(vspan_reg),
    .extra_front(extra_vblank_reg), // [R12]
    .seg(vseg),
    .pos(vpos),
    .wrap(vwrap)
  );

  assign line_active = (vseg == seg_active);
  assign pix_active = line_active && (hseg == seg_active); // [R8]
  assign vblank_now = !line_active;

  // band lookup: last band whose first line is not above the current line
  always_comb
  begin
    cur_band = 2'd0;
    for (int i = 1; i < `MAX_SCREEN_BANDS; i++)
    begin
      if ((2'(i) <= band_count_reg) && (vpos >= band_reg[i].first_line))
      begin
        cur_band = 2'(i); // [R6]
      end
    end
  end

  assign src_line = reverse_line_order_reg ? (vspan_reg.active - 12'h001 - vpos) : vpos; // [R3] [R5]
  assign src_dot = reverse_dot_order_reg ? (hspan_reg.active - 12'h001 - hpos) : hpos; // [R4] [R5]

  // wrap inside the buffer so a larger buffer can be panned via band base
  always_comb
  begin
    logic [`ADDR_W-1:0] off;
    off = 17'(src_line) * 17'(line_pitch_reg) + 17'(src_dot) + band_reg[cur_band].base;
    if (off >= frame_pixel_count_reg)
    begin
      off = off - frame_pixel_count_reg; // [R1]
    end
    pix_addr = buf_base_reg[shown_buf_reg] + off; // [R2]
  end

  // fetch is issued on the launch edge of each active dot
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fetch <= '0;
    end
    else
    begin
      fetch.req <= launch && pix_active && scan_enable_reg; // [R8]
      fetch.addr <= pix_addr;
    end
  end

  // panel outputs
  always_ff @(posedge clk)
  begin
    if (rst || !scan_enable_reg)
    begin
      panel <= '0; // [R22]
    end
    else
    begin
      if (launch)
      begin
        panel.hsync <= (hseg == seg_pulse); // [R17] [R21]
        panel.vsync <= (vseg == seg_pulse); // [R18] [R22]
        panel.data_en <= pix_active; // [R19]
      end
      if (fetch_valid)
      begin
        panel.rgb <= fetch_data; // [R20]
      end
      else if (launch && !pix_active)
      begin
        panel.rgb <= 16'h0000;
      end
    end
  end

  // buffer switch and rate changes take effect at frame boundary, or on every clock while scan is disabled
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      shown_buf_reg <= '0;
      applied_active_div_reg <= `DEF_ACTIVE_DIV;
      applied_blank_div_reg <= `DEF_BLANK_DIV;
      frame_count_reg <= 16'h0000;
    end
    else if (vwrap || !scan_enable_reg)
    begin
      shown_buf_reg <= buf_sel_reg; // [R2]
      if (!rate_error_reg)
      begin
        applied_active_div_reg <= active_div_reg; // [R9] [R11]
      end
      applied_blank_div_reg <= blank_div_reg; // [R10]
      frame_count_reg <= frame_count_reg + 16'h0001;
    end
  end

  // vblank edge event, one cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vblank_prev_reg <= 1'b1;
      vblank_event <= 1'b0;
    end
    else
    begin
      vblank_prev_reg <= vblank_now;
      vblank_event <= scan_enable_reg && (vblank_now != vblank_prev_reg); // [R15]
    end
  end

  // approximate active share in dot counts; percent compare avoids a divider
  assign active_dots = 24'(vspan_reg.active) * 24'(hspan_reg.active);
  assign total_dots = 24'(vspan_reg.pulse + vspan_reg.back + vspan_reg.active
                      + vspan_reg.front + extra_vblank_reg)
                      * 24'(hspan_reg.pulse + hspan_reg.back + hspan_reg.active
                      + hspan_reg.front);
  assign share_ok = (32'(active_dots) * 32'(`PCT_MAX))
                    <= (32'(total_dots) * 32'(`PCT_MAX - min_host_access_share_reg)); // [R13]

  // register writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reverse_line_order_reg <= 1'b0;
      reverse_dot_order_reg <= 1'b0;
      falling_edge_latch_select_reg <= 1'b0;
      scan_enable_reg <= 1'b0;
      buf_sel_reg <= '0;
      band_count_reg <= '0;
      hspan_reg <= {`DEF_H_PULSE, `DEF_H_BACK, `DEF_H_ACTIVE, `DEF_H_FRONT};
      vspan_reg <= {`DEF_V_PULSE, `DEF_V_BACK, `DEF_V_ACTIVE, `DEF_V_FRONT};
      active_div_reg <= `DEF_ACTIVE_DIV;
      blank_div_reg <= `DEF_BLANK_DIV;
      extra_vblank_reg <= 12'h000;
      frame_pixel_count_reg <= 17'(`DEF_H_ACTIVE) * 17'(`DEF_V_ACTIVE); // [R1]
      line_pitch_reg <= `DEF_H_ACTIVE;
      min_host_access_share_reg <= 8'h00;
      rate_error_reg <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        buf_base_reg[i] <= '0;
        band_reg[i] <= '0;
      end
    end
    else if (reg_write)
    begin
      unique case (reg_addr)
        A_CTRL:
        begin
          scan_enable_reg <= reg_wdata[0];
          reverse_line_order_reg <= reg_wdata[1]; // [R3]
          reverse_dot_order_reg <= reg_wdata[2]; // [R4]
          falling_edge_latch_select_reg <= reg_wdata[3]; // [R16]
          band_count_reg <= reg_wdata[5:4]; // [R6]
          buf_sel_reg <= reg_wdata[7:6];
        end
        A_HSPAN0: {hspan_reg.pulse, hspan_reg.back} <= {reg_wdata[27:16], reg_wdata[11:0]};
        A_HSPAN1: {hspan_reg.active, hspan_reg.front} <= {reg_wdata[27:16], reg_wdata[11:0]};
        A_VSPAN0: {vspan_reg.pulse, vspan_reg.back} <= {reg_wdata[27:16], reg_wdata[11:0]};
        A_VSPAN1: {vspan_reg.active, vspan_reg.front} <= {reg_wdata[27:16], reg_wdata[11:0]};
        A_RATE:
        begin
          // divisor below the memory limit is refused, old rate kept
          rate_error_reg <= (reg_wdata[7:0] < `MIN_ACTIVE_DIV); // [R11]
          if (reg_wdata[7:0] >= `MIN_ACTIVE_DIV)
          begin
            active_div_reg <= reg_wdata[7:0]; // [R9]
          end
          if (reg_wdata[15:8] >= `MIN_DIV)
          begin
            blank_div_reg <= reg_wdata[15:8]; // [R10]
          end
          min_host_access_share_reg <= reg_wdata[23:16]; // [R13]
        end
        A_FRAME:
        begin
          extra_vblank_reg <= reg_wdata[11:0]; // [R12]
          line_pitch_reg <= reg_wdata[27:16];
        end
        A_STATUS: frame_pixel_count_reg <= reg_wdata[16:0]; // [R1]
        A_BUF, A_BUF + 6'h04, A_BUF + 6'h08, A_BUF + 6'h0C:
          buf_base_reg[reg_addr[3:2]] <= reg_wdata[16:0];
        A_BAND, A_BAND + 6'h04, A_BAND + 6'h08, A_BAND + 6'h0C:
          band_reg[reg_addr[3:2]] <= {reg_wdata[16:0], reg_wdata[28:17]}; // [R6]
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      share_error_reg <= 1'b0;
    end
    else
    begin
      share_error_reg <= !share_ok; // [R13]
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk)
  begin
    if (rst || !reg_read)
    begin
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      unique case (reg_addr)
        A_CTRL: reg_rdata <= {24'h000000, buf_sel_reg, band_count_reg,
                              falling_edge_latch_select_reg, reverse_dot_order_reg,
                              reverse_line_order_reg, scan_enable_reg};
        A_HSPAN0: reg_rdata <= {4'h0, hspan_reg.pulse, 4'h0, hspan_reg.back};
        A_HSPAN1: reg_rdata <= {4'h0, hspan_reg.active, 4'h0, hspan_reg.front};
        A_VSPAN0: reg_rdata <= {4'h0, vspan_reg.pulse, 4'h0, vspan_reg.back};
        A_VSPAN1: reg_rdata <= {4'h0, vspan_reg.active, 4'h0, vspan_reg.front};
        A_RATE: reg_rdata <= {8'h00, min_host_access_share_reg, blank_div_reg, active_div_reg};
        A_FRAME: reg_rdata <= {4'h0, line_pitch_reg, 4'h0, extra_vblank_reg};
        A_STATUS: reg_rdata <= {frame_count_reg[9:0], share_error_reg, rate_error_reg,
                                vblank_now, shown_buf_reg, frame_pixel_count_reg};
        A_BUF, A_BUF + 6'h04, A_BUF + 6'h08, A_BUF + 6'h0C:
          reg_rdata <= {15'h0000, buf_base_reg[reg_addr[3:2]]};
        A_BAND, A_BAND + 6'h04, A_BAND + 6'h08, A_BAND + 6'h0C:
          reg_rdata <= {3'h0, band_reg[reg_addr[3:2]].first_line,
                        band_reg[reg_addr[3:2]].base};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule // panel_scan_timing

// >>> tb/panel_scan_timing_props.sv
// assertion checker bound to the panel scan timing block
`timescale 1ns/10ps
`include "panel_scan_consts.svh"
module panel_scan_timing_props
  import panel_scan_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input panel_scan_pkg::fetch_type fetch,
  input wire logic [`PIX_W-1:0] fetch_data,
  input wire logic fetch_valid,
  input wire logic dot_clk,
  input panel_scan_pkg::panel_type panel,
  input wire logic vblank_event
);
  logic dot_prev_reg;
  logic [7:0] still_reg;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // the slowest legal divider holds a level for under 128 clocks
  always_ff @(posedge clk)
  begin
    dot_prev_reg <= dot_clk;
    if (rst || dot_clk != dot_prev_reg)
      still_reg <= 8'h00;
    else
      still_reg <= still_reg + 8'h01;
  end
  dot_running_a: assert property (still_reg < 8'hC8)
    else $error("dot clock stalled");
  reset_idle_a: assert property ($past(rst) |->
    (panel == '0 && !dot_clk && !fetch.req && !vblank_event))
    else $error("outputs not idle after reset");
  blank_rgb_a: assert property (!panel.data_en |-> panel.rgb == 16'h0000)
    else $error("pixel data outside data window");
  sync_apart_a: assert property (panel.data_en |-> !panel.hsync && !panel.vsync)
    else $error("data window overlaps sync");
  fetch_window_a: assert property (fetch.req |-> panel.data_en)
    else $error("fetch outside data window");
  fetch_pulse_a: assert property (fetch.req |=> !fetch.req)
    else $error("fetch request longer than one cycle");
  vblank_pulse_a: assert property (vblank_event |=> !vblank_event)
    else $error("vblank event longer than one cycle");
  rgb_setup_a: assert property (($changed(panel.rgb) && $changed(dot_clk))
    |-> $changed(panel.data_en))
    else $error("pixel data changed on a latching dot clock edge");
endmodule // panel_scan_timing_props

bind panel_scan_timing panel_scan_timing_props u_props (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .fetch(fetch), .fetch_data(fetch_data), .fetch_valid(fetch_valid),
  .dot_clk(dot_clk), .panel(panel), .vblank_event(vblank_event));

// >>> tb/panel_model.sv
// panel side model: latches pixels on its selected dot clock edge
`timescale 1ns/10ps
module panel_model
  import panel_scan_pkg::*;
(
  input wire logic clk,
  input wire logic dot_clk,
  input wire logic falling_latch,
  input panel_scan_pkg::panel_type panel
);
  logic [15:0] pix [0:63];
  int count = 0;
  logic dot_prev_reg = 1'b0;
  logic vs_prev_reg = 1'b0;
  // edges are found on the system clock so the latch never races the data update
  always @(posedge clk)
  begin
    dot_prev_reg <= dot_clk;
    vs_prev_reg <= panel.vsync;
    if (vs_prev_reg && !panel.vsync)
      count <= 0;
    else if (dot_clk != dot_prev_reg && dot_clk != falling_latch && panel.data_en && count < 64)
    begin
      pix[count] <= panel.rgb;
      count <= count + 1;
    end
  end
endmodule // panel_model

// >>> tb/rgb_panel_scan_timing_bench.sv
// self-checking bench for the panel scan timing block
`timescale 1ns/10ps
`include "panel_scan_consts.svh"
module rgb_panel_scan_timing_bench;
  import panel_scan_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  fetch_type fetch;
  logic [15:0] fetch_data = 16'h0;
  logic fetch_valid = 1'b0;
  logic dot_clk;
  panel_type panel;
  logic vblank_event;
  logic falling_latch = 1'b0;
  logic [31:0] q;
  logic [3:0] modes [4] = '{4'h0, 4'h1, 4'h2, 4'hF};
  int num_errors = 0;
  int checked = 0;
  int n;
  int ev;
  always #2 clk = ~clk;
  // memory answers one clock after each request, well inside the dot time
  always @(posedge clk)
  begin
    fetch_valid <= fetch.req;
    fetch_data <= fetch.addr[15:0] ^ 16'hC3A5;
  end
  panel_scan_timing DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .fetch(fetch),
    .fetch_data(fetch_data), .fetch_valid(fetch_valid), .dot_clk(dot_clk), .panel(panel),
    .vblank_event(vblank_event));
  panel_model pm (.clk(clk), .dot_clk(dot_clk), .falling_latch(falling_latch), .panel(panel));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    q = reg_rdata;
  endtask
  // returns clocks to the next rising sync edge and vblank events seen meanwhile
  task automatic wait_rise(input bit vs);
    logic p;
    logic s;
    n = 0;
    ev = 0;
    p = 1'b1;
    s = 1'b1;
    while (!(p === 1'b0 && s === 1'b1))
    begin
      p = vs ? panel.vsync : panel.hsync;
      @(posedge clk);
      s = vs ? panel.vsync : panel.hsync;
      n++;
      if (vblank_event === 1'b1)
        ev++;
      if (n > 2000)
      begin
        $display("BAD sync edge expected 1 seen 0");
        num_errors++;
        end_of_test;
      end
    end
  endtask
  task automatic test_scan_modes;
    logic [16:0] a;
    for (int i = 0; i < 4; i++)
    begin
      wr(6'h00, {24'h0, 1'b0, modes[i][3], 2'b00, modes[i][2:0], 1'b1});
      falling_latch <= modes[i][2];
      repeat (3) wait_rise(1'b1);
      chk("frame clocks", 32'd480, n);
      chk("vblank events", 32'd2, ev);
      chk("pixel count", 32'd12, pm.count);
      for (int l = 0; l < 3; l++)
        for (int d = 0; d < 4; d++)
        begin
          a = (modes[i][3] ? 17'h00100 : 17'h00000)
            + 17'((modes[i][0] ? 2 - l : l) * 4 + (modes[i][1] ? 3 - d : d));
          chk("pixel", {16'h0, a[15:0] ^ 16'hC3A5}, pm.pix[l * 4 + d]);
        end
      $display("test scan mode %0d done", i);
    end
  endtask
  task automatic test_bands;
    logic [16:0] a;
    wr(6'h34, {3'h0, 12'h002, 17'h00004});
    wr(6'h00, 32'h0000_0011);
    falling_latch <= 1'b0;
    repeat (3) wait_rise(1'b1);
    chk("band pixel count", 32'd12, pm.count);
    for (int k = 0; k < 12; k++)
    begin
      a = 17'((k < 8) ? k : k - 8);
      chk("band pixel", {16'h0, a[15:0] ^ 16'hC3A5}, pm.pix[k]);
    end
    $display("test bands done");
  endtask
  task automatic test_timing;
    wait_rise(1'b0);
    wait_rise(1'b0);
    chk("line clocks", 32'd80, n);
    wr(6'h18, 32'h0004_0002);
    repeat (3) wait_rise(1'b1);
    chk("stretched frame clocks", 32'd640, n);
    wr(6'h18, 32'h0004_0000);
    wr(6'h14, 32'h0000_0806);
    repeat (3) wait_rise(1'b1);
    chk("dual rate frame clocks", 32'd456, n);
    wr(6'h14, 32'h0000_0801);
    rd(6'h14);
    chk("kept active divider", {24'h0, 8'h06}, {24'h0, q[7:0]});
    rd(6'h1C);
    chk("rate error flag", 32'h1, {31'h0, q[20]});
    chk("share error clear", 32'h0, {31'h0, q[21]});
    wr(6'h14, 32'h005A_0806);
    rd(6'h1C);
    chk("share error flag", 32'h1, {31'h0, q[21]});
    chk("rate error cleared", 32'h0, {31'h0, q[20]});
    $display("test timing done");
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(6'h04);
    chk("line timing after reset", 32'h0029_0002, q);
    chk("panel idle", 32'h0, {12'h0, panel.hsync, panel.vsync, panel.data_en, panel.rgb});
    wr(6'h04, 32'h0002_0002);
    wr(6'h08, 32'h0004_0002);
    wr(6'h0C, 32'h0001_0001);
    wr(6'h10, 32'h0003_0001);
    wr(6'h14, 32'h0000_0808);
    wr(6'h18, 32'h0004_0000);
    wr(6'h1C, 32'h0000_000C);
    wr(6'h24, 32'h0000_0100);
    $display("test reset and setup done");
    test_scan_modes;
    test_bands;
    test_timing;
    end_of_test;
  end
endmodule // rgb_panel_scan_timing_bench
